/* File: logic/counter_block_params.svh */
// register offsets, field positions, reset values and timing counts of the counter block
`ifndef COUNTER_BLOCK_PARAMS_SVH
`define COUNTER_BLOCK_PARAMS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_MODE 8'h00
`define OFS_ENABLE 8'h04
`define OFS_COMMAND 8'h08
`define OFS_EVENT_COUNT 8'h0C
`define OFS_LATCH_A 8'h10
`define OFS_PWM_COUNT 8'h14
`define OFS_PWM_SINGLE 8'h18
`define OFS_STATUS 8'h1C
`define OFS_BANK_BASE 8'h20
`define OFS_BANK_LAST 8'h4C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ENABLE_EVENT_BIT 0
`define ENABLE_PWM_BIT 1
`define CMD_EVENT_CLEAR_BIT 0
`define CMD_EVENT_CAPTURE_BIT 1
`define CMD_PWM_CAPTURE_BIT 2
`define CMD_SYNC_CAPTURE_BIT 3
`define MODE_WIDTH 9

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define MODE_RESET 9'h000
`define ENABLE_RESET 2'h0
`define COUNT_RESET 32'h0000_0000

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CORE_CLK_MHZ 20
`define PWM_REF_MHZ 100
`define PWM_TICKS_PER_CLK (`PWM_REF_MHZ / `CORE_CLK_MHZ)
`define BANK_WORDS 12

`endif

/* File: logic/counter_block_pkg.sv */
// types shared by the counter block and its capture bank
package counter_block_pkg;

  // per-counter mode field, bit 0 at the bottom
  typedef struct packed {
    logic pwm_on_zc;      // bit 8: zero/capture input carries the pwm signal
    logic pwm_on_b;       // bit 7: direction input carries the pwm signal
    logic ref_rising;     // bit 6: rising edge is the reference edge
    logic zc_enable;      // bit 5: zero/capture input enabled
    logic zc_capture;     // bit 4: 1 capture into latch A, 0 zero the counter
    logic invert_b;       // bit 3
    logic invert_a;       // bit 2
    logic zc_level;       // bit 1: 1 acts while high, 0 acts on rising edge
    logic quadrature;     // bit 0: 1 four-edge, 0 clock/direction
  } mode_type;

  typedef struct packed {
    logic sync_capture;
    logic pwm_capture;
    logic event_capture;
    logic event_clear;
  } command_type;

  // edge events from the selected pwm input
  typedef struct packed {
    logic rise;
    logic fall;
  } pwm_edge_type;

endpackage : counter_block_pkg

/* File: logic/counter_block_pwm_capture.sv */
// counter block: event counter, pwm counter with capture levels, ahb-lite registers
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "counter_block_params.svh"

// Contract
// - pwm counter advances from a 100 MHz reference, not from external inputs
// - pwm counter captured on both edges of chosen input; selected polarity is the reference edge
// - software may command a capture of the current counter value anytime
// - high zero/capture input zeroes counter or copies it into latch A
// - clock/direction: each rising count edge steps by one, direction high counts up
// - count and direction inputs can each be inverted by mode bits
// - quadrature direction follows the order of edges of both inputs
// - quadrature: every edge on either input steps the counter by one
// - two independent 32-bit counters: up/down event counter and pwm counter
// - three rising and three falling capture levels, each with a shadow
// - rising edge loads rise level 1; rising reference shifts both chains
// - falling edge loads fall level 1; falling reference shifts fall chain
// - single pwm capture register loaded only by software capture command
// - sync capture copies all counters and levels into shadows at once
// - enable, clear and capture commands take a per-counter bit mask; clear has a bit for the event counter only
// - mode bits 0-5: mode, clear mode, inversions, clear/capture, enable
// - mode bit 6 picks rising reference, bits 7 and 8 pick pwm input
module counter_block_pwm_capture
  import counter_block_pkg::*;
#(
  parameter int unsigned PWM_STEP = `PWM_TICKS_PER_CLK
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // external pulse inputs
  input wire logic count_pulse_in,
  input wire logic direction_in,
  input wire logic zero_or_capture_input,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  // a step of zero would freeze the pwm counter and make every level equal;
  // the upper bound keeps one core period well below a wrap of the counter
  if (PWM_STEP < 1 || PWM_STEP > 255) begin : gen_step_check
    $error("PWM_STEP out of range");
  end

  // ----------------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------------
  function automatic logic is_bank(input logic [7:0] a);
    return (a >= `OFS_BANK_BASE) && (a <= `OFS_BANK_LAST) && (a[1:0] == 2'h0);
  endfunction : is_bank

  function automatic logic [3:0] bank_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - `OFS_BANK_BASE;
    return d[5:2];
  endfunction : bank_index

  // a write lands at the edge that ends its data phase
  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
    return wr && (a == ofs);
  endfunction : wr_hit

  // four-edge step: 2'b01 up, 2'b10 down, 2'b00 none or illegal double change
  function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
    case ({prev, cur})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'h1;
      4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'h2;
      default: quad_step = 2'h0;
    endcase
  endfunction : quad_step

  // ----------------------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------------------
  // three stages; a level is accepted only once stages two and three agree,
  // which drops single-cycle glitches at the cost of one extra cycle of delay
  logic [2:0] pin_raw;
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic [2:0] pin_level;
  logic [2:0] pin_prev;

  assign pin_raw = {zero_or_capture_input, direction_in, count_pulse_in};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_level <= 3'h0;
      pin_prev <= 3'h0;
    end else begin
      pin_level <= (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_level);
      pin_prev <= pin_level;
    end
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  mode_type mode;
  logic [1:0] run_mask;
  command_type cmd;
  logic [31:0] event_count;
  logic [31:0] latch_a;
  logic [31:0] pwm_count;
  logic [31:0] pwm_single;

  // bus pipeline
  logic addr_valid;
  logic wr_pending;
  logic [7:0] wr_addr;
  logic rd_bank;
  logic [31:0] rd_reg;
  logic [31:0] bank_rd_data;

  assign addr_valid = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pending <= addr_valid && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode <= `MODE_RESET;
    end else if (wr_hit(wr_pending, wr_addr, `OFS_MODE)) begin
      mode <= hwdata[`MODE_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_mask <= `ENABLE_RESET;
    end else if (wr_hit(wr_pending, wr_addr, `OFS_ENABLE)) begin
      run_mask <= hwdata[1:0];
    end
  end

  // commands are one-cycle pulses out of the write data phase
  always_comb begin
    cmd = '0;
    if (wr_hit(wr_pending, wr_addr, `OFS_COMMAND)) begin
      cmd.event_clear = hwdata[`CMD_EVENT_CLEAR_BIT];
      cmd.event_capture = hwdata[`CMD_EVENT_CAPTURE_BIT];
      cmd.pwm_capture = hwdata[`CMD_PWM_CAPTURE_BIT];
      cmd.sync_capture = hwdata[`CMD_SYNC_CAPTURE_BIT];
    end
  end

  // ----------------------------------------------------------------------------
  // event counter
  // ----------------------------------------------------------------------------
  logic cnt_a;
  logic cnt_b;
  logic cnt_a_prev;
  logic cnt_b_prev;
  logic zc_rise;
  logic zc_act;
  logic step_up;
  logic step_down;
  logic [1:0] quad;

  assign cnt_a = pin_level[0] ^ mode.invert_a;
  assign cnt_b = pin_level[1] ^ mode.invert_b;
  assign cnt_a_prev = pin_prev[0] ^ mode.invert_a;
  assign cnt_b_prev = pin_prev[1] ^ mode.invert_b;
  assign zc_rise = pin_level[2] && !pin_prev[2];
  assign zc_act = mode.zc_enable && (mode.zc_level ? pin_level[2] : zc_rise);
  assign quad = quad_step({cnt_a_prev, cnt_b_prev}, {cnt_a, cnt_b});

  always_comb begin
    step_up = 1'b0;
    step_down = 1'b0;
    if (mode.quadrature) begin
      step_up = quad[0];
      step_down = quad[1];
    end else if (cnt_a && !cnt_a_prev) begin
      step_up = cnt_b;
      step_down = !cnt_b;
    end
  end

  // clearing beats counting: a step landing in the clear cycle is dropped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      event_count <= `COUNT_RESET;
    end else if (cmd.event_clear || (zc_act && !mode.zc_capture)) begin
      event_count <= `COUNT_RESET;
    end else if (run_mask[`ENABLE_EVENT_BIT]) begin
      if (step_up) begin
        event_count <= event_count + 32'h0000_0001;
      end else if (step_down) begin
        event_count <= event_count - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      latch_a <= `COUNT_RESET;
    end else if (cmd.event_capture || cmd.sync_capture || (zc_act && mode.zc_capture)) begin
      latch_a <= event_count;
    end
  end

  // ----------------------------------------------------------------------------
  // pwm counter
  // ----------------------------------------------------------------------------
  // the 100 MHz reference is modelled as PWM_STEP ticks per core clock, so the
  // measured resolution is one core period even though units stay 10 ns
  logic pwm_in;
  logic pwm_in_prev;
  pwm_edge_type pwm_edge;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwm_count <= `COUNT_RESET;
    end else if (run_mask[`ENABLE_PWM_BIT]) begin
      pwm_count <= pwm_count + 32'(PWM_STEP);
    end
  end

  always_comb begin
    pwm_in = pin_level[0];
    pwm_in_prev = pin_prev[0];
    if (mode.pwm_on_zc) begin
      pwm_in = pin_level[2];
      pwm_in_prev = pin_prev[2];
    end else if (mode.pwm_on_b) begin
      pwm_in = pin_level[1];
      pwm_in_prev = pin_prev[1];
    end
  end

  // edges are only taken while the pwm counter runs
  assign pwm_edge.rise = run_mask[`ENABLE_PWM_BIT] && pwm_in && !pwm_in_prev;
  assign pwm_edge.fall = run_mask[`ENABLE_PWM_BIT] && !pwm_in && pwm_in_prev;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwm_single <= `COUNT_RESET;
    end else if (cmd.pwm_capture || cmd.sync_capture) begin
      pwm_single <= pwm_count;
    end
  end

  pwm_level_bank u_bank (
    .core_clk(core_clk),
    .rst(rst),
    .edge_evt(pwm_edge),
    .ref_rising(mode.ref_rising),
    .shadow_copy(cmd.sync_capture),
    .count_value(pwm_count),
    .rd_index(bank_index(haddr[7:0])),
    .rd_data(bank_rd_data)
  );

  // ----------------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------------
  // both the bank and rd_reg register at the address-phase edge, so every read
  // is answered with no wait state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_bank <= 1'b0;
      rd_reg <= 32'h0000_0000;
    end else if (addr_valid && !hwrite) begin
      rd_bank <= is_bank(haddr[7:0]);
      case (haddr[7:0])
        `OFS_MODE: rd_reg <= {23'h000000, mode};
        `OFS_ENABLE: rd_reg <= {30'h00000000, run_mask};
        `OFS_EVENT_COUNT: rd_reg <= event_count;
        `OFS_LATCH_A: rd_reg <= latch_a;
        `OFS_PWM_COUNT: rd_reg <= pwm_count;
        `OFS_PWM_SINGLE: rd_reg <= pwm_single;
        `OFS_STATUS: rd_reg <= {29'h00000000, pin_level};
        default: rd_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // bank read hold
  // ----------------------------------------------------------------------------
  // the bank's read register follows haddr every cycle and its levels move on
  // every pwm edge, so its word is copied once at the end of the data phase;
  // hrdata then stands until the next read is taken
  logic bank_fresh;
  logic [31:0] bank_hold;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bank_fresh <= 1'b0;
    end else begin
      bank_fresh <= addr_valid && !hwrite;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bank_hold <= 32'h0000_0000;
    end else if (bank_fresh) begin
      bank_hold <= bank_rd_data;
    end
  end

  // software computes period from the shadowed levels 2 and 3, and high time too with a rising reference
  assign hrdata = rd_bank ? (bank_fresh ? bank_rd_data : bank_hold) : rd_reg;

endmodule : counter_block_pwm_capture

/* File: logic/pwm_level_bank.sv */
// pwm capture levels with shadow copies, registered read port
`timescale 1ns/1ps
`include "counter_block_params.svh"

module pwm_level_bank
  import counter_block_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // capture events
  input wire pwm_edge_type edge_evt,
  input wire logic ref_rising,
  input wire logic shadow_copy,
  input wire logic [31:0] count_value,
  // read port
  input wire logic [3:0] rd_index,
  output logic [31:0] rd_data
);

  logic [31:0] rise_lvl [3];
  logic [31:0] fall_lvl [3];
  logic [31:0] rise_shd [3];
  logic [31:0] fall_shd [3];

  // ----------------------------------------------------------------------------
  // live levels
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        rise_lvl[i] <= `COUNT_RESET;
      end
    end else if (edge_evt.rise) begin
      rise_lvl[0] <= count_value;
      if (ref_rising) begin
        rise_lvl[2] <= rise_lvl[1];
        rise_lvl[1] <= rise_lvl[0];
      end
    end else if (edge_evt.fall && !ref_rising) begin
      rise_lvl[2] <= rise_lvl[2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        fall_lvl[i] <= `COUNT_RESET;
      end
    end else if (edge_evt.fall) begin
      fall_lvl[0] <= count_value;
      if (!ref_rising) begin
        fall_lvl[2] <= fall_lvl[1];
        fall_lvl[1] <= fall_lvl[0];
      end
    end else if (edge_evt.rise && ref_rising) begin
      fall_lvl[2] <= fall_lvl[1];
      fall_lvl[1] <= fall_lvl[0];
    end
  end

  // ----------------------------------------------------------------------------
  // shadows take the pre-edge levels when an edge lands in the copy cycle
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        rise_shd[i] <= `COUNT_RESET;
        fall_shd[i] <= `COUNT_RESET;
      end
    end else if (shadow_copy) begin
      for (int i = 0; i < 3; i++) begin
        rise_shd[i] <= rise_lvl[i];
        fall_shd[i] <= fall_lvl[i];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data <= `COUNT_RESET;
    end else begin
      case (rd_index)
        4'h0: rd_data <= rise_lvl[0];
        4'h1: rd_data <= rise_lvl[1];
        4'h2: rd_data <= rise_lvl[2];
        4'h3: rd_data <= fall_lvl[0];
        4'h4: rd_data <= fall_lvl[1];
        4'h5: rd_data <= fall_lvl[2];
        4'h6: rd_data <= rise_shd[0];
        4'h7: rd_data <= rise_shd[1];
        4'h8: rd_data <= rise_shd[2];
        4'h9: rd_data <= fall_shd[0];
        4'hA: rd_data <= fall_shd[1];
        4'hB: rd_data <= fall_shd[2];
        default: rd_data <= `COUNT_RESET;
      endcase
    end
  end

endmodule : pwm_level_bank

/* File: tb/counter_block_monitor.sv */
// bus and pwm counter checker for the counter block
`timescale 1ns/1ps
`include "counter_block_params.svh"
module counter_block_monitor #(
  parameter int unsigned PWM_STEP = 5
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp
);
  logic rd;
  logic rd_pwm;
  logic en_wr;
  logic pwm_run;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  assign rd_pwm = rd && haddr[7:0] == `OFS_PWM_COUNT;
  // mirror of the pwm run bit, so the rate check knows when the count may move
  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_wr <= 1'b0;
      pwm_run <= 1'b0;
    end else begin
      en_wr <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == `OFS_ENABLE;
      if (en_wr) begin
        pwm_run <= hwdata[`ENABLE_PWM_BIT];
      end
    end
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // two count reads one idle cycle apart, run bit steady meanwhile
  sequence pwm_pair_s(r);
    rd_pwm && pwm_run == r ##1 pwm_run == r ##1 rd_pwm;
  endsequence
  hready_const_a: assert property (hreadyout == 1'b1) else $error("hreadyout low");
  okay_resp_a: assert property (hresp == 1'b0) else $error("hresp not okay");
  rdata_hold_a:
    assert property (!$past(rd) && !$past(rst) |-> $stable(hrdata))
    else $error("hrdata moved without a read");
  cmd_zero_a:
    assert property (rd && haddr[7:0] == `OFS_COMMAND |=> hrdata == 32'h0)
    else $error("command read not zero");
  unmapped_zero_a:
    assert property (rd && (haddr[7:0] > `OFS_BANK_LAST || haddr[1:0] != 2'h0)
      |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  mode_width_a:
    assert property (rd && haddr[7:0] == `OFS_MODE |=> hrdata[31:9] == 23'h0)
    else $error("mode upper bits set");
  pwm_step_a:
    assert property (pwm_pair_s(1'b1) |=> hrdata == $past(hrdata, 2) + 32'(2 * PWM_STEP))
    else $error("pwm count rate wrong");
  pwm_hold_a:
    assert property (pwm_pair_s(1'b0) |=> hrdata == $past(hrdata, 2))
    else $error("stopped pwm count moved");
endmodule : counter_block_monitor

bind counter_block_pwm_capture counter_block_monitor #(.PWM_STEP(PWM_STEP)) u_monitor (
  .core_clk(core_clk),
  .rst(rst),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hreadyout(hreadyout),
  .hrdata(hrdata),
  .hresp(hresp)
);

/* File: tb/pulse_source.sv */
// encoder and pulse source facing the counter block pins
`timescale 1ns/1ps
module pulse_source (
  // clock
  input wire logic core_clk,
  // pins
  output logic pin_a,
  output logic pin_b,
  output logic pin_z
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    pin_z = 1'b0;
  end
  // levels are always driven, so the pull-downs never decide the pin
  task automatic drive(input logic a, input logic b, input logic z, input int hold);
    @(posedge core_clk);
    pin_a <= a;
    pin_b <= b;
    pin_z <= z;
    repeat (hold) @(posedge core_clk);
  endtask : drive
endmodule : pulse_source

/* File: tb/tb_counter_block_pwm_capture.sv */
// self-checking testbench of the counter block
`timescale 1ns/1ps
`include "counter_block_params.svh"
module tb_counter_block_pwm_capture;
  localparam int unsigned STEP = 5;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic pin_a;
  logic pin_b;
  logic pin_z;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] exp;
  logic [31:0] q;
  logic d;
  int p;

  assign hready = hreadyout;
  always #25 core_clk = ~core_clk;

  counter_block_pwm_capture #(.PWM_STEP(STEP)) u_dut (.core_clk(core_clk), .rst(rst),
    .count_pulse_in(pin_a), .direction_in(pin_b), .zero_or_capture_input(pin_z),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp));
  pulse_source u_src (.core_clk(core_clk), .pin_a(pin_a), .pin_b(pin_b), .pin_z(pin_z));

  // --------
  // helpers
  // --------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  function automatic logic [31:0] ticks(input int n);
    return 32'(n * STEP);
  endfunction : ticks

  task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : check

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus(a, 1'b1, wd, x);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string s);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0, x);
    check(s, e, x);
  endtask : rd_chk

  // four periods on one input, then a sync capture and a look at the bank
  task automatic pwm_case(input int src, input logic rise_ref);
    int hi;
    int lo;
    logic [31:0] s [12];
    hi = 4 + $urandom_range(8);
    lo = 4 + $urandom_range(8);
    wr(`OFS_MODE, {23'h0, src == 2, src == 1, rise_ref, 6'h0});
    repeat (4) begin
      u_src.drive(src == 0, src == 1, src == 2, hi);
      u_src.drive(1'b0, 1'b0, 1'b0, lo);
    end
    wr(`OFS_COMMAND, 32'h8);
    for (int k = 0; k < 12; k++) begin
      bus(8'(`OFS_BANK_BASE + 4 * k), 1'b0, 32'h0, s[k]);
    end
    if (rise_ref) begin
      check("high", ticks(hi + 1), s[11] - s[8]);
      check("period", ticks(hi + lo + 2), s[7] - s[8]);
    end else begin
      check("period", ticks(hi + lo + 2), s[10] - s[11]);
    end
    check("shadow", s[4], s[10]);
  endtask : pwm_case

  // --------
  // tests
  // --------
  initial begin
    void'($urandom(69276));
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 21; i++) begin
      rd_chk(8'(4 * i), 32'h0, "reset word");
    end
    rd_chk(8'h06, 32'h0, "unaligned");
    $display("reset test done");
    exp = {23'h0, 9'($urandom())};
    wr(`OFS_MODE, exp | 32'hFFFF_FE00);
    rd_chk(`OFS_MODE, exp, "mode");
    wr(`OFS_ENABLE, 32'hFFFF_FFFC);
    rd_chk(`OFS_PWM_COUNT, 32'h0, "pwm stopped");
    rd_chk(`OFS_PWM_COUNT, 32'h0, "pwm stopped");
    wr(`OFS_ENABLE, 32'h1);
    for (int inv = 0; inv < 4; inv++) begin
      wr(`OFS_MODE, 32'(inv << 2));
      u_src.drive(inv[0], inv[1], 1'b0, 6);
      wr(`OFS_COMMAND, 32'h1);
      exp = 32'h0;
      repeat (6) begin
        d = 1'($urandom());
        u_src.drive(inv[0], d ^ inv[1], 1'b0, 4);
        u_src.drive(!inv[0], d ^ inv[1], 1'b0, 4);
        exp = exp + (d ? 32'h1 : 32'hFFFF_FFFF);
      end
      u_src.drive(inv[0], inv[1], 1'b0, 4);
      rd_chk(`OFS_EVENT_COUNT, exp, "clock dir");
    end
    $display("clock direction test done");
    wr(`OFS_MODE, 32'h1);
    u_src.drive(1'b0, 1'b0, 1'b0, 6);
    wr(`OFS_COMMAND, 32'h1);
    exp = 32'h0;
    p = 0;
    repeat (24) begin
      d = 1'($urandom());
      p = d ? (p + 1) % 4 : (p + 3) % 4;
      u_src.drive(p == 1 || p == 2, p >= 2, 1'b0, 4);
      exp = exp + (d ? 32'h1 : 32'hFFFF_FFFF);
    end
    u_src.drive(p == 1 || p == 2, p >= 2, 1'b0, 4);
    rd_chk(`OFS_EVENT_COUNT, exp, "quadrature");
    $display("quadrature test done");
    wr(`OFS_MODE, 32'h30);
    u_src.drive(1'b0, 1'b0, 1'b0, 6);
    wr(`OFS_COMMAND, 32'h1);
    repeat (3) begin
      u_src.drive(1'b1, 1'b1, 1'b0, 4);
      u_src.drive(1'b0, 1'b1, 1'b0, 4);
    end
    u_src.drive(1'b0, 1'b1, 1'b1, 6);
    rd_chk(`OFS_LATCH_A, 32'h3, "zc latch");
    rd_chk(`OFS_EVENT_COUNT, 32'h3, "count kept");
    rd_chk(`OFS_STATUS, 32'h6, "status");
    wr(`OFS_MODE, 32'h20);
    u_src.drive(1'b0, 1'b1, 1'b0, 6);
    u_src.drive(1'b0, 1'b1, 1'b1, 6);
    rd_chk(`OFS_EVENT_COUNT, 32'h0, "zc zero");
    u_src.drive(1'b1, 1'b1, 1'b0, 4);
    wr(`OFS_COMMAND, 32'h2);
    rd_chk(`OFS_LATCH_A, 32'h1, "soft latch");
    wr(`OFS_MODE, 32'h22);
    u_src.drive(1'b0, 1'b1, 1'b1, 4);
    u_src.drive(1'b1, 1'b1, 1'b1, 6);
    rd_chk(`OFS_EVENT_COUNT, 32'h0, "zc level");
    $display("clear capture test done");
    wr(`OFS_ENABLE, 32'h2);
    u_src.drive(1'b0, 1'b0, 1'b0, 6);
    bus(`OFS_PWM_COUNT, 1'b0, 32'h0, q);
    rd_chk(`OFS_PWM_COUNT, q + ticks(2), "pwm rate");
    for (int i = 0; i < 4; i++) begin
      pwm_case(i % 3, i < 3);
    end
    rd_chk(`OFS_EVENT_COUNT, 32'h0, "event idle");
    bus(`OFS_PWM_COUNT, 1'b0, 32'h0, q);
    wr(`OFS_COMMAND, 32'h4);
    rd_chk(`OFS_PWM_SINGLE, q + ticks(3), "single");
    u_src.drive(1'b1, 1'b0, 1'b0, 6);
    u_src.drive(1'b0, 1'b0, 1'b0, 6);
    rd_chk(`OFS_PWM_SINGLE, q + ticks(3), "single held");
    $display("pwm test done");
    wrap_up();
  end
endmodule : tb_counter_block_pwm_capture
